/* adcs_cfg.svh */
// Constants for the conversion sequencer: register offsets, fields, reset values, timing.
// Included by the prescaler and the sequencer; definitions only.
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// Register offsets (byte addresses on the plain port)
`define ADCS_OFS_CTRL0 4'h0
`define ADCS_OFS_CTRL1 4'h1
`define ADCS_OFS_CTRL2 4'h2
`define ADCS_OFS_RES_HI 4'h3
`define ADCS_OFS_RES_LO 4'h4
`define ADCS_OFS_FLAG 4'h5

// Control 0 fields
`define ADCS_BIT_ENABLE 0
`define ADCS_BIT_BUSY 1
`define ADCS_CHS_LSB 2
`define ADCS_CHS_MSB 5
// Control 2 fields
`define ADCS_CCS_LSB 0
`define ADCS_CCS_MSB 2
`define ADCS_ACQ_LSB 3
`define ADCS_ACQ_MSB 5
`define ADCS_BIT_RJUST 7
// Flag register fields
`define ADCS_BIT_DONE 0
`define ADCS_BIT_IRQEN 1

// Reset values
`define ADCS_RST_CTRL0 8'h00
`define ADCS_RST_CTRL1 8'h00
`define ADCS_RST_CTRL2 8'h00
`define ADCS_RST_FLAG 8'h00

// Timing in conversion-clock periods
`define ADCS_CONV_PERIODS 4'hB
`define ADCS_HOLDOFF_PERIODS 4'h2
// Sleep slot delay for RC clock, one instruction cycle of four oscillator periods
`define ADCS_INSTR_CYCLES 3'h4
// Result width in bits
`define ADCS_RESULT_BITS 10

`endif

/* adcs_pkg.sv */
// Types for the conversion sequencer.
// Assumes adcs_cfg.svh sits in the include path.
`default_nettype none
package adcs_pkg;
  typedef enum logic [2:0] {
    ADCS_IDLE = 3'b000,
    ADCS_SLOT = 3'b001,
    ADCS_ACQ = 3'b010,
    ADCS_CONV = 3'b011,
    ADCS_HOLD = 3'b100
  } adcs_state_t;
endpackage
`default_nettype wire

/* adcs_prescaler.sv */
// Conversion-clock tick source: divides the oscillator or follows the RC oscillator.
// Assumes rc_osc_tick is already synchronised to clk by the caller.
`default_nettype none
`include "adcs_cfg.svh"
module adcs_prescaler
  import adcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic rc_osc_tick,
  // Output
  output logic tick
);
  logic [5:0] count_reg;
  logic [5:0] count_next;
  logic [5:0] ratio_m1;
  logic [6:0] ratio;
  logic rc_sel;
  logic div_wrap;

  // Code to ratio: 000/2 100/4 001/8 101/16 010/32 110/64
  assign rc_sel = (clk_sel[1:0] == 2'b11); // R10
  assign ratio = 7'h02 << {clk_sel[1:0], clk_sel[2]}; // R10
  assign ratio_m1 = 6'(ratio - 7'h01);
  assign div_wrap = (count_reg == ratio_m1);
  assign count_next = (!run || div_wrap) ? 6'h00 : count_reg + 6'h01;
  assign tick = run && (rc_sel ? rc_osc_tick : div_wrap); // R22

  always_ff @(posedge clk)
  begin
    if (srst)
      count_reg <= 6'h00;
    else
      count_reg <= count_next;
  end
endmodule // adcs_prescaler
`default_nettype wire

/* adcs_period_counter.sv */
// Counts conversion-clock ticks up to a target and flags the last one.
// Assumes tick is a one-cycle pulse on clk.
`default_nettype none
module adcs_period_counter
  import adcs_pkg::*;
#(
  parameter int WIDTH = 5
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [WIDTH-1:0] target,
  // Status
  output logic reached
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  assign reached = tick && (count_reg == target - WIDTH'(1)); // R23
  assign count_next = clear ? '0 : (tick ? count_reg + WIDTH'(1) : count_reg);

  always_ff @(posedge clk)
  begin
    if (srst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end
endmodule // adcs_period_counter
`default_nettype wire

/* adcs_sequencer.sv */
// Conversion sequencer for a 10-bit successive-approximation converter.
// Assumes a plain register port, a synchronised-here RC oscillator pin and
// an analog converter that returns a result, timed here by counting conv_step pulses.
// Result bytes have no reset; they mean nothing before a conversion or write.
// Notes on behaviour
// R1 - Result registers not cleared by reset
// R2 - Optional acquisition interval before conversion
// R3 - Software configures, starts, waits, reads result
// R4 - Two conversion-clock periods hold-off after conversion
// R5 - Zero acquisition field starts conversion immediately
// R6 - Nonzero field samples programmed periods first
// R7 - Completion clears busy, sets flag, resamples
// R8 - Busy set through acquisition and conversion
// R9 - Conversion lasts eleven conversion-clock periods
// R10 - Clock select code maps divider or RC
// R11 - Software picks shortest legal clock period
// R12 - RC clock above 1 MHz needs Sleep
// R13 - Reprogram fields for low-power; clock stable
// R14 - Below 1 MHz select RC clock
// R15 - RC with zero field delays one cycle
// R16 - Sleep conversion needs idle bit cleared
// R17 - Channel change needs full acquisition time
// R18 - Acquisition codes give 0..20 periods
// R19 - Busy reads one while active
// R20 - Clearing busy aborts, result kept
// R21 - Reset disables converter, aborts conversion
// R22 - Prescaler divides oscillator or passes RC
// R23 - Counter times acquisition in clock periods
`default_nettype none
`include "adcs_cfg.svh"
module adcs_sequencer
  import adcs_pkg::*;
#(
  parameter int RESULT_BITS = `ADCS_RESULT_BITS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // RC oscillator pin
  input wire logic rc_osc_in,
  // Analog side
  output logic sample_en,
  output logic conv_start,
  output logic conv_step,
  output logic [3:0] channel_sel,
  input wire logic [RESULT_BITS-1:0] conv_result,
  // Status
  output logic conv_done_flag,
  output logic conv_done_irq_enable
);
  adcs_state_t state_reg;
  adcs_state_t state_next;
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic done_reg;
  logic irqen_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [2:0] slot_reg;
  logic rc_sync1_reg;
  logic rc_sync2_reg;
  logic rc_prev_reg;

  logic converter_enable_bit;
  logic busy;
  logic [2:0] acq_time_sel;
  logic [2:0] conv_clock_sel;
  logic rc_selected;
  logic rc_tick;
  logic ad_tick;
  logic run_clk;
  logic phase_clear;
  logic [4:0] phase_target;
  logic phase_done;
  logic [4:0] acq_periods;
  logic wr_ctrl0;
  logic wr_ctrl2;
  logic wr_reshi;
  logic wr_reslo;
  logic wr_flag;
  logic sw_go;
  logic sw_abort;
  logic finish;
  logic [15:0] result_word;

  // Decodes shared by several processes
  logic wr_ctrl1;
  logic div_run;
  logic load_result;
  logic [2:0] slot_next;
  logic in_idle;
  logic in_slot;
  logic in_acq;
  logic in_conv;
  logic in_hold;
  logic [7:0] ctrl0_image;
  logic [7:0] flag_image;

  // State decodes
  assign in_idle = (state_reg == ADCS_IDLE);
  assign in_slot = (state_reg == ADCS_SLOT);
  assign in_acq = (state_reg == ADCS_ACQ);
  assign in_conv = (state_reg == ADCS_CONV);
  assign in_hold = (state_reg == ADCS_HOLD);

  // Decoding
  assign wr_ctrl0 = reg_wr && (reg_addr == `ADCS_OFS_CTRL0);
  assign wr_ctrl1 = reg_wr && (reg_addr == `ADCS_OFS_CTRL1);
  assign wr_ctrl2 = reg_wr && (reg_addr == `ADCS_OFS_CTRL2);
  assign wr_reshi = reg_wr && (reg_addr == `ADCS_OFS_RES_HI);
  assign wr_reslo = reg_wr && (reg_addr == `ADCS_OFS_RES_LO);
  assign wr_flag = reg_wr && (reg_addr == `ADCS_OFS_FLAG);
  assign converter_enable_bit = ctrl0_reg[`ADCS_BIT_ENABLE];
  assign acq_time_sel = ctrl2_reg[`ADCS_ACQ_MSB:`ADCS_ACQ_LSB];
  assign conv_clock_sel = ctrl2_reg[`ADCS_CCS_MSB:`ADCS_CCS_LSB];
  assign rc_selected = (conv_clock_sel[1:0] == 2'b11);
  assign busy = !in_idle && !in_hold; // R8 R19
  // Start only when idle and enabled; a start with enable in the same write is ignored
  assign sw_go = wr_ctrl0 && reg_wdata[`ADCS_BIT_BUSY] && converter_enable_bit
    && reg_wdata[`ADCS_BIT_ENABLE] && in_idle;
  // Clearing busy or enable mid-run drops the partial result
  assign sw_abort = busy && ((wr_ctrl0 && !reg_wdata[`ADCS_BIT_BUSY])
    || !converter_enable_bit); // R20
  assign finish = in_conv && phase_done;
  assign load_result = finish && !sw_abort; // R7 R20

  // Acquisition code to periods: 0 2 4 6 8 12 16 20
  assign acq_periods = (acq_time_sel <= 3'h4) ? {1'b0, acq_time_sel, 1'b0}
    : 5'(({2'b00, acq_time_sel} - 5'h2) << 2); // R18

  // RC oscillator edge, two flops before use
  assign rc_tick = rc_sync2_reg && !rc_prev_reg;
  assign run_clk = in_acq || in_conv || in_hold;

  // Divider idles outside timed phases and restarts on abort,
  // so the hold-off after a busy-bit abort with enable still set spans two full periods on divider clocks
  assign div_run = run_clk && !sw_abort; // R4

  adcs_prescaler u_prescaler (
    .clk(clk),
    .srst(srst),
    .run(div_run),
    .clk_sel(conv_clock_sel),
    .rc_osc_tick(rc_tick),
    .tick(ad_tick)
  );

  // One counter shared by acquisition, conversion and hold-off
  assign phase_target = (state_reg == ADCS_ACQ) ? acq_periods // R23
    : (state_reg == ADCS_CONV) ? {1'b0, `ADCS_CONV_PERIODS} // R9
    : {1'b0, `ADCS_HOLDOFF_PERIODS}; // R4
  assign phase_clear = (state_next != state_reg);

  adcs_period_counter #(.WIDTH(5)) u_phase (
    .clk(clk),
    .srst(srst),
    .clear(phase_clear),
    .tick(ad_tick),
    .target(phase_target),
    .reached(phase_done)
  );

  // Sequence: idle, sleep slot or acquisition, conversion, hold-off
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ADCS_IDLE:
        if (sw_go)
        begin
          if (acq_time_sel != 3'b000)
            state_next = ADCS_ACQ; // R2 R6
          else if (rc_selected)
            state_next = ADCS_SLOT; // R15
          else
            state_next = ADCS_CONV; // R5
        end
      ADCS_SLOT:
        if (sw_abort)
          state_next = ADCS_HOLD;
        else if (slot_reg == `ADCS_INSTR_CYCLES - 3'h1)
          state_next = ADCS_CONV;
      ADCS_ACQ:
        if (sw_abort)
          state_next = ADCS_HOLD;
        else if (phase_done)
          state_next = ADCS_CONV;
      ADCS_CONV:
        if (sw_abort || phase_done)
          state_next = ADCS_HOLD; // R7 R20
      ADCS_HOLD:
        if (phase_done || !converter_enable_bit)
          state_next = ADCS_IDLE; // R4
      default:
        state_next = ADCS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= ADCS_IDLE; // R21
    else
      state_reg <= state_next;
  end

  // Sleep slot counted in system clocks, not in conversion-clock periods
  assign slot_next = in_slot ? slot_reg + 3'h1 : 3'h0; // R15
  always_ff @(posedge clk)
  begin
    if (srst)
      slot_reg <= 3'h0;
    else
      slot_reg <= slot_next;
  end

  // Pin synchroniser; the first flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rc_sync1_reg <= 1'b0;
      rc_sync2_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end
    else
    begin
      rc_sync1_reg <= rc_osc_in;
      rc_sync2_reg <= rc_sync1_reg;
      rc_prev_reg <= rc_sync2_reg;
    end
  end

  // Control registers; busy bit is state, not stored
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl0_reg <= `ADCS_RST_CTRL0; // R21
    else if (wr_ctrl0)
      ctrl0_reg <= {2'b00, reg_wdata[5:2], 1'b0, reg_wdata[0]};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl1_reg <= `ADCS_RST_CTRL1;
    else if (wr_ctrl1)
      ctrl1_reg <= {2'b00, reg_wdata[5:0]};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl2_reg <= `ADCS_RST_CTRL2;
    else if (wr_ctrl2)
      ctrl2_reg <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irqen_reg <= 1'b0;
    else if (wr_flag)
      irqen_reg <= reg_wdata[`ADCS_BIT_IRQEN];
  end

  // Completion flag; a completion beats a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      done_reg <= 1'b0;
    else if (load_result)
      done_reg <= 1'b1; // R7
    else if (wr_flag)
      done_reg <= reg_wdata[`ADCS_BIT_DONE];
  end

  // Result justification
  assign result_word = ctrl2_reg[`ADCS_BIT_RJUST]
    ? 16'({6'h00, conv_result}) : 16'({conv_result, 6'h00});

  // Result bytes keep their value across reset on purpose
  always_ff @(posedge clk)
  begin
    if (load_result)
    begin
      result_high_byte <= result_word[15:8]; // R1 R20
      result_low_byte <= result_word[7:0];
    end
    else
    begin
      if (wr_reshi)
        result_high_byte <= reg_wdata;
      if (wr_reslo)
        result_low_byte <= reg_wdata;
    end
  end

  // Read images; reserved bits read zero
  assign ctrl0_image = {ctrl0_reg[7:2], busy, ctrl0_reg[0]}; // R19
  assign flag_image = {6'h00, irqen_reg, done_reg};

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      `ADCS_OFS_CTRL0: rdata_next = ctrl0_image; // R19
      `ADCS_OFS_CTRL1: rdata_next = ctrl1_reg;
      `ADCS_OFS_CTRL2: rdata_next = ctrl2_reg;
      `ADCS_OFS_RES_HI: rdata_next = result_high_byte;
      `ADCS_OFS_RES_LO: rdata_next = result_low_byte;
      `ADCS_OFS_FLAG: rdata_next = flag_image;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stands one cycle only; zero otherwise so a stale read cannot alias
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= reg_rd ? rdata_next : 8'h00;
  end

  // Analog side: sampling resumes once hold-off ends
  assign sample_en = converter_enable_bit && (in_idle || in_acq); // R6 R7
  // Start leads the conversion by one cycle so the hold stage isolates first
  assign conv_start = (state_reg != ADCS_CONV) && (state_next == ADCS_CONV);
  assign conv_step = in_conv && ad_tick;
  assign channel_sel = ctrl0_reg[`ADCS_CHS_MSB:`ADCS_CHS_LSB];

  // Register port and status outputs
  assign reg_rdata = rdata_reg;
  assign conv_done_flag = done_reg;
  assign conv_done_irq_enable = irqen_reg;
endmodule // adcs_sequencer
`default_nettype wire

/* adcs_seq_asserts.sv */
// Port checker for the conversion sequencer, bound to its top module.
// Assumes no flag write lands on the edge that completes a conversion.
`default_nettype none
module adcs_seq_asserts
  import adcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  // Analog side and status
  input wire logic sample_en,
  input wire logic conv_start,
  input wire logic conv_step,
  input wire logic conv_done_flag,
  input wire logic conv_done_irq_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] step_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk)
  begin
    if (srst || conv_start)
      step_cnt <= {3'h0, conv_step};
    else if (conv_step)
      step_cnt <= step_cnt + 4'h1;
  end
  // Completion only, not a software write of the flag
  sequence done_s;
    $rose(conv_done_flag) && !$past(reg_wr);
  endsequence
  a_step_count: assert property (done_s |-> step_cnt == 4'hB) else $error("step count");
  a_conv_quiet: assert property (conv_step |-> !sample_en) else $error("sampling");
  a_start_stops: assert property (conv_start |=> !sample_en) else $error("no stop");
  a_holdoff_min: assert property (done_s |-> !sample_en [*3]) else $error("hold-off");
  a_resample_after: assert property (done_s |-> ##[1:400] sample_en)
    else $error("no resample");
  a_flag_keep: assert property (conv_done_flag && !(reg_wr && reg_addr == 4'h5)
    |=> conv_done_flag) else $error("flag lost");
  a_step_gap: assert property (conv_step |=> !conv_step) else $error("steps adjacent");
  a_reset_idle: assert property (disable iff (1'b0)
    srst |=> !sample_en && !conv_done_flag && !conv_done_irq_enable) else $error("reset");
  c_done: cover property (done_s);
  c_start: cover property (conv_start);
  c_irq: cover property (conv_done_flag && conv_done_irq_enable);
endmodule // adcs_seq_asserts
bind adcs_sequencer adcs_seq_asserts chk (.clk, .srst, .reg_addr, .reg_wr, .sample_en,
  .conv_start, .conv_step, .conv_done_flag, .conv_done_irq_enable);
`default_nettype wire

/* adcs_analog_model.sv */
// Converter and RC oscillator model on the analog side of the sequencer.
// Assumes conv_start and conv_step are one-cycle pulses on clk.
`default_nettype none
module adcs_analog_model
(
  // Clock
  input wire logic clk,
  // Converter control
  input wire logic conv_start,
  input wire logic conv_step,
  input wire logic [3:0] channel_sel,
  // Result and RC oscillator
  output logic [9:0] conv_result,
  output logic rc_osc_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held = 10'h000;
  logic [3:0] steps = 4'h0;
  logic active = 1'b0;
  // Scrambled outside a conversion so a late sample shows
  assign conv_result = active ? held : ~held;
  initial
  begin
    rc_osc_in = 1'b0;
    forever #130 rc_osc_in = ~rc_osc_in;
  end
  always @(posedge clk)
  begin
    if (conv_start)
    begin
      held <= {channel_sel, 6'h15};
      active <= 1'b1;
      steps <= 4'h0;
    end
    else if (conv_step)
    begin
      steps <= steps + 4'h1;
      active <= (steps != 4'hA);
    end
  end
endmodule // adcs_analog_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the analog model and the bound checker are compiled with it.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, reg_wr, reg_rd, rc_osc_in, sample_en, conv_start, conv_step, rj;
  logic conv_done_flag, conv_done_irq_enable;
  logic [3:0] reg_addr, channel_sel;
  logic [7:0] reg_wdata, reg_rdata;
  logic [9:0] conv_result, last;
  int bad_count, total_checks, cyc, n_steps, t_first, t_last, t_start, t_go;
  int ratio[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int acqp[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  adcs_sequencer DUT (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rc_osc_in, .sample_en, .conv_start, .conv_step, .channel_sel, .conv_result,
    .conv_done_flag, .conv_done_irq_enable);
  adcs_analog_model model (.clk, .conv_start, .conv_step, .channel_sel, .conv_result,
    .rc_osc_in);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (conv_start)
      t_start <= cyc;
    if (conv_step)
      t_last <= cyc;
    if (conv_step)
      n_steps <= n_steps + 1;
    if (conv_step && n_steps == 0)
      t_first <= cyc;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chkreg(input logic [3:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {24'h0, e}, {24'h0, reg_rdata});
  endtask
  task automatic wait_sample();
    for (int i = 0; i < 400 && sample_en !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("resample", 1, sample_en);
  endtask
  task automatic go_steps(input int n);
    n_steps = 0;
    wr(4'h0, 8'h17);
    for (int i = 0; i < 400 && n_steps < n; i++)
      @(posedge clk);
  endtask
  task automatic run_conv(input logic [7:0] c0, input int lo, input int hi);
    logic [9:0] res;
    res = {c0[5:2], 6'h15};
    n_steps = 0;
    wr(4'h0, c0 | 8'h02);
    t_go = cyc;
    chkreg(4'h0, c0 | 8'h02, "busy set");
    for (int i = 0; i < 2000 && conv_done_flag !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("done flag", 1, conv_done_flag);
    chk("start latency", 1, t_start - t_go >= lo && t_start - t_go <= hi);
    chk("steps", 11, n_steps);
    chkreg(4'h0, c0, "busy clear");
    chkreg(4'h3, rj ? {6'h0, res[9:8]} : res[9:2], "result high");
    chkreg(4'h4, rj ? res[7:0] : {res[1:0], 6'h0}, "result low");
    last = res;
    wr(4'h5, 8'h02);
    wait_sample();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial
  begin
    srst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rj = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 7; a++)
      if (a != 3 && a != 4)
        chkreg(4'(a), 8'h00, "reset value");
    wr(4'h2, 8'hFF);
    chkreg(4'h2, 8'hBF, "ctrl2 fields");
    wr(4'h1, 8'hFF);
    chkreg(4'h1, 8'h3F, "ctrl1 fields");
    wr(4'h6, 8'hFF);
    chkreg(4'h6, 8'h00, "unmapped");
    wr(4'h5, 8'h02);
    #1;
    chk("irq enable", 1, conv_done_irq_enable);
    wr(4'h0, 8'h15);
    for (int c = 0; c < 8; c++)
    begin
      wr(4'h2, 8'h80 | 8'(c));
      wr(4'h0, {2'h0, 4'(c), 2'h1});
      repeat (4) @(posedge clk);
      run_conv({2'h0, 4'(c), 2'h1}, (c % 4 == 3) ? 4 : 0, (c % 4 == 3) ? 6 : 0);
      if (ratio[c] != 0)
        chk("step span", 10 * ratio[c], t_last - t_first);
    end
    wr(4'h2, 8'h86);
    go_steps(3);
    wr(4'h0, 8'h15);
    wait_sample();
    chk("abort flag", 0, conv_done_flag);
    chkreg(4'h4, last[7:0], "kept result");
    go_steps(2);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("reset flag", 0, conv_done_flag);
    chkreg(4'h0, 8'h00, "reset ctrl0");
    chkreg(4'h3, {6'h0, last[9:8]}, "result kept");
    wr(4'h4, 8'hA5);
    chkreg(4'h4, 8'hA5, "result write");
    rj = 1'b0;
    wr(4'h0, 8'h15);
    for (int a = 0; a < 8; a++)
    begin
      wr(4'h2, 8'(a * 8));
      run_conv(8'h15, acqp[a] * 2 - 1, acqp[a] * 2 + 3);
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
